// *** design/acc_ctrl.sv ***
// Conversion, sleep and data-output cycle control with serial port.
// Assumes an analog core answering conv_start_o with conv_done_i,
// and an APB master on the reference clock.
// Operation
// - Serial input bits are taken on rising serial clock edges.
// - Input word selects rejection, temperature input and double speed.
// - Select low enables serial pins and wakes the converter.
// - After conversion, sleep while select stays high.
// - Select rising during output aborts and starts a new conversion.
// - Serial output floats whenever select is high.
// - In conversion or sleep with select low, output shows status.
// - In data output the serial output carries the result bits.
// - Internal clock mode drives the clock pin during data output.
// - Clock mode taken from clock pin at reset and select fall.
// - Weak pull-up on clock pin in internal clock mode.
// - Control pin low: conversion clock from internal oscillator.
// - Clock on control pin replaces the internal oscillator.
// - Overrange and underrange give distinct result codes.
// - Result bits shift out on falling serial clock edges.
// - Update flag, three ignored, temp, two reject, double speed.
// - Temperature input forces normal speed.
// - Select high before any rising edge: back to sleep, keep result.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
module acc_ctrl
  import acc_pkg::*;
#(
  parameter int EXT_IDLE = EXT_IDLE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  // Serial pins
  input wire logic cs_n_i,
  input wire logic serial_config_in_i,
  output logic serial_result_out_o,
  output logic serial_result_out_oe_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  output logic sck_pullup_o,
  input wire logic conv_clock_control_i,
  // Analog core side
  input wire logic conv_done_i,
  input wire logic [24:0] conv_result_i,
  input wire logic conv_over_i,
  input wire logic conv_under_i,
  output logic conv_start_o,
  output logic conv_tick_o,
  output logic sleep_o,
  output logic temp_input_select_o,
  output logic reject_select_a_o,
  output logic reject_select_b_o,
  output logic double_rate_select_o
);
  acc_state_t state_q, state_d;
  logic [3:0] pins_s, pins_p_q;
  logic int_mode_q, isck_q, sdo_q, sdo_oe_q, ext_act_q;
  logic sck_oe_q, pull_q, conv_start_q, conv_tick_q;
  logic [8:0] osc_cnt_q;
  logic [15:0] idle_cnt_q;
  logic [2:0] boot_q;
  logic [1:0] half_cnt_q;
  logic [5:0] bit_cnt_q;
  logic [31:0] shift_q, word_q;
  logic [7:0] cfg_sh_q;
  logic [3:0] mode_q;
  logic [EV_N-1:0] irq_st_q, irq_en_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, irq_q;

  // Pin synchronisers; select inverted so reset reads deselected
  acc_sync #(
    .W(4)
  ) u_sync (
    .clk_i(ref_clk_i),
    .rst_i(sys_rst_i),
    .d_i({conv_clock_control_i, serial_config_in_i, sck_i, ~cs_n_i}),
    .q_o(pins_s)
  );

  // Synchronised levels and edges
  wire cs_n_s = ~pins_s[0];
  wire sck_s = pins_s[1];
  wire sdi_s = pins_s[2];
  wire f0_s = pins_s[3];
  wire cs_fall = pins_p_q[0] & ~cs_n_s;
  wire cs_rise = ~pins_p_q[0] & cs_n_s;
  wire esck_rise = ~pins_p_q[1] & sck_s;
  wire esck_fall = pins_p_q[1] & ~sck_s;
  wire f0_rise = ~pins_p_q[3] & f0_s;

  // Conversion clock select and tick
  wire osc_wrap = (osc_cnt_q == OSC_DIV_LAST);
  wire conv_tick = ext_act_q ? f0_rise : osc_wrap;

  // Data output gating and internal shift clock
  wire in_dout = (state_q == ACC_DOUT);
  wire io_en = in_dout & ~cs_n_s;
  wire frame_end = (bit_cnt_q == FRAME_BITS);
  wire isck_tog = io_en & int_mode_q & conv_tick &
                  (half_cnt_q == ISCK_HALF_LAST) & (~frame_end | isck_q);
  wire sck_rise = int_mode_q ? (isck_tog & ~isck_q) : (io_en & esck_rise);
  wire sck_fall = int_mode_q ? (isck_tog & isck_q) : (io_en & esck_fall);
  wire got_rise = (bit_cnt_q != 6'h00);
  wire frame_done = sck_fall & frame_end;
  wire aborted = in_dout & cs_rise & got_rise & ~frame_end;
  wire back_sleep = in_dout & cs_rise & ~got_rise;
  wire dout_exit = frame_done | aborted | (in_dout & cs_rise & frame_end);

  // Configuration word decode at the end of a transfer
  wire cfg_full = (bit_cnt_q >= CFG_BITS);
  wire cfg_rsvd = cfg_sh_q[CFG_FA] & cfg_sh_q[CFG_FB];
  wire cfg_apply = dout_exit & cfg_full & cfg_sh_q[CFG_EN] & ~cfg_rsvd;
  wire [3:0] cfg_word = {cfg_sh_q[CFG_SPD], cfg_sh_q[CFG_FB],
                         cfg_sh_q[CFG_FA], cfg_sh_q[CFG_IM]};

  // Result word: low end-of-conversion flag, dummy, payload
  wire [29:0] payload = conv_over_i ? WORD_OVER :
                        conv_under_i ? WORD_UNDER :
                        {~conv_result_i[24], conv_result_i, 4'h0};

  // APB decode
  wire apb_acc = psel_i & penable_i & ~pready_q;
  wire apb_done = psel_i & penable_i & pready_q;
  wire hit_cfg = (paddr_i == OFS_CFG);
  wire hit_stat = (paddr_i == OFS_STATUS);
  wire hit_res = (paddr_i == OFS_RESULT);
  wire hit_ist = (paddr_i == OFS_IRQ_STAT);
  wire hit_ien = (paddr_i == OFS_IRQ_EN);
  wire hit_icl = (paddr_i == OFS_IRQ_CLR);
  wire hit_any = hit_cfg | hit_stat | hit_res | hit_ist | hit_ien | hit_icl;
  wire wr_ok = apb_done & pwrite_i & ~pslverr_q;
  wire [31:0] status_word = {16'h0000, 2'h0, bit_cnt_q, 3'h0,
                             ext_act_q, int_mode_q, 3'(state_q)};
  wire [31:0] rd_mux = hit_cfg ? {28'h0000000, mode_q} :
                       hit_stat ? status_word :
                       hit_res ? word_q :
                       hit_ist ? {28'h0000000, irq_st_q} :
                       hit_ien ? {28'h0000000, irq_en_q} : 32'h00000000;

  // Interrupt events
  wire [EV_N-1:0] ev = {cfg_apply, aborted, frame_done,
                        (state_q == ACC_CONV) & conv_done_i};
  wire [EV_N-1:0] ev_clr = (wr_ok & hit_icl) ? pwdata_i[EV_N-1:0] : '0;

  // Cycle state transitions
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ACC_CONV: if (conv_done_i) state_d = ACC_SLEEP;
      ACC_SLEEP: if (~cs_n_s) state_d = ACC_DOUT;
      ACC_DOUT: begin
        if (dout_exit) begin
          state_d = ACC_CONV;
        end else if (back_sleep) begin
          state_d = ACC_SLEEP;
        end
      end
    endcase
  end

  // State, boot and pin history
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= ACC_CONV;
      boot_q <= 3'b001;
      pins_p_q <= 4'h1;
    end else begin
      state_q <= state_d;
      boot_q <= {boot_q[1:0], 1'b0};
      pins_p_q <= {pins_s[3:1], cs_n_s};
    end
  end

  // Conversion start pulse and sleep flag
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conv_start_q <= 1'b0;
      sleep_o <= 1'b0;
    end else begin
      conv_start_q <= boot_q[2] | (in_dout & (state_d == ACC_CONV));
      sleep_o <= (state_d == ACC_SLEEP);
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      int_mode_q <= 1'b1;
    end else if (boot_q[2] | cs_fall) begin
      int_mode_q <= sck_s;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      osc_cnt_q <= 9'h000;
    end else begin
      osc_cnt_q <= osc_wrap ? 9'h000 : osc_cnt_q + 9'h001;
    end
  end

  // external clock detect on control pin
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      idle_cnt_q <= 16'h0000;
      ext_act_q <= 1'b0;
    end else if (f0_rise) begin
      idle_cnt_q <= 16'h0000;
      ext_act_q <= 1'b1;
    end else if (idle_cnt_q == 16'(EXT_IDLE)) begin
      ext_act_q <= 1'b0;
    end else begin
      idle_cnt_q <= idle_cnt_q + 16'h0001;
    end
  end

  // Conversion tick out to the modulator
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conv_tick_q <= 1'b0;
    end else begin
      conv_tick_q <= conv_tick;
    end
  end

  // internal shift clock, eighth of conversion clock
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      half_cnt_q <= 2'h0;
      isck_q <= 1'b0;
    end else if (~io_en | ~int_mode_q) begin
      half_cnt_q <= 2'h0;
      isck_q <= 1'b0;
    end else if (conv_tick) begin
      half_cnt_q <= half_cnt_q + 2'h1;
      if (isck_tog) isck_q <= ~isck_q;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      word_q <= 32'h00000000;
    end else if ((state_q == ACC_CONV) & conv_done_i) begin
      word_q <= {2'b00, payload};
    end
  end

  // sample input on rising edge, count bits
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bit_cnt_q <= 6'h00;
      cfg_sh_q <= 8'h00;
    end else if (~in_dout) begin
      bit_cnt_q <= 6'h00;
      cfg_sh_q <= 8'h00;
    end else if (sck_rise & ~frame_end) begin
      bit_cnt_q <= bit_cnt_q + 6'h01;
      if (~cfg_full) cfg_sh_q <= {cfg_sh_q[6:0], sdi_s};
    end
  end

  // shift result out on falling edges
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift_q <= 32'h00000000;
    end else if (~in_dout) begin
      shift_q <= word_q;
    end else if (sck_fall & got_rise) begin
      shift_q <= {shift_q[30:0], 1'b0};
    end
  end

  // mode register from serial word or software
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_q <= MODE_RESET;
    end else if (cfg_apply) begin
      mode_q <= cfg_word;
    end else if (wr_ok & hit_cfg) begin
      mode_q <= pwdata_i[3:0];
    end
  end

  // Mode outputs to the analog core
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      temp_input_select_o <= 1'b0;
      reject_select_a_o <= 1'b0;
      reject_select_b_o <= 1'b0;
      double_rate_select_o <= 1'b0;
    end else begin
      temp_input_select_o <= mode_q[MODE_IM];
      reject_select_a_o <= mode_q[MODE_FA];
      reject_select_b_o <= mode_q[MODE_FB];
      double_rate_select_o <= mode_q[MODE_SPD] & ~mode_q[MODE_IM];
    end
  end

  // Serial output pin and clock pin drive
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
      sck_oe_q <= 1'b0;
      pull_q <= 1'b0;
    end else begin
      sdo_q <= in_dout ? shift_q[31] : (state_q == ACC_CONV);
      sdo_oe_q <= ~cs_n_s;
      // drive clock pin in internal mode
      sck_oe_q <= io_en & int_mode_q;
      pull_q <= int_mode_q;
    end
  end

  // APB answer: one wait state, registered data
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= apb_acc;
      pslverr_q <= apb_acc & ~hit_any;
      prdata_q <= (apb_acc & ~pwrite_i) ? rd_mux : 32'h00000000;
    end
  end

  // Sticky events, set wins over clear
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_st_q <= '0;
      irq_en_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_st_q <= (irq_st_q & ~ev_clr) | ev;
      if (wr_ok & hit_ien) irq_en_q <= pwdata_i[EV_N-1:0];
      irq_q <= |(irq_st_q & irq_en_q);
    end
  end

  // Output assignments from flops
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign irq_o = irq_q;
  assign serial_result_out_o = sdo_q;
  assign serial_result_out_oe_o = sdo_oe_q;
  assign sck_o = isck_q;
  assign sck_oe_o = sck_oe_q;
  assign sck_pullup_o = pull_q;
  assign conv_start_o = conv_start_q;
  assign conv_tick_o = conv_tick_q;
endmodule

// *** inc/acc_pkg.sv ***
// Constants for the converter serial cycle controller.
// Assumes a 100 MHz reference clock and an APB register bus.
package acc_pkg;
  // Reference clock and conversion clock rates
  localparam int CLK_HZ = 100000000;
  localparam int CLK_NS = 10;
  localparam int OSC_HZ = 307200;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam logic [8:0] OSC_DIV_LAST = 9'(OSC_DIV - 1);
  // Longest external conversion clock phase, then idle timeout
  localparam int EXT_IDLE_NS = 100000;
  localparam int EXT_IDLE_CYC = EXT_IDLE_NS / CLK_NS;
  // Internal shift clock: four conversion ticks per half period
  localparam logic [1:0] ISCK_HALF_LAST = 2'h3;
  // Frame layout
  localparam logic [5:0] FRAME_BITS = 6'h20;
  localparam logic [5:0] CFG_BITS = 6'h08;
  localparam int CFG_EN = 7;
  localparam int CFG_IM = 3;
  localparam int CFG_FA = 2;
  localparam int CFG_FB = 1;
  localparam int CFG_SPD = 0;
  // Register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_EN = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
  // Mode register fields: temp, reject a, reject b, double rate
  localparam int MODE_IM = 0;
  localparam int MODE_FA = 1;
  localparam int MODE_FB = 2;
  localparam int MODE_SPD = 3;
  localparam logic [3:0] MODE_RESET = 4'h0;
  // Interrupt event bits
  localparam int EV_CONV_DONE = 0;
  localparam int EV_FRAME_DONE = 1;
  localparam int EV_ABORT = 2;
  localparam int EV_CFG_UPD = 3;
  localparam int EV_N = 4;
  // Overrange and underrange payloads
  localparam logic [29:0] WORD_OVER = 30'h30000000;
  localparam logic [29:0] WORD_UNDER = 30'h0fffffff;
  // Cycle states, one-hot
  typedef enum logic [2:0] {
    ACC_CONV = 3'b001,
    ACC_SLEEP = 3'b010,
    ACC_DOUT = 3'b100
  } acc_state_t;
endpackage

// *** design/acc_sync.sv ***
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to clk_i.
`timescale 1ns/1ps
module acc_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule

// *** tb/acc_assertions.sv ***
// Port checker for the converter cycle controller.
// Assumes binding onto acc_ctrl, one reference clock domain.
`timescale 1ns/1ps
module acc_assertions
  import acc_pkg::*;
#(
  parameter int EXT_IDLE = EXT_IDLE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic serial_result_out_oe_o,
  input wire logic sck_oe_o,
  input wire logic sck_pullup_o,
  input wire logic conv_done_i,
  input wire logic conv_tick_o,
  input wire logic sleep_o,
  input wire logic temp_input_select_o,
  input wire logic reject_select_a_o,
  input wire logic reject_select_b_o,
  input wire logic double_rate_select_o
);
  logic [15:0] gap_q;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Cycles since the last conversion tick
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i || conv_tick_o) begin
      gap_q <= 16'h0000;
    end else begin
      gap_q <= gap_q + 16'h0001;
    end
  end
  a_float_deselect: assert property (
    cs_n_i [*4] |-> !serial_result_out_oe_o)
    else $error("serial out driven while deselected");
  a_select_drives: assert property (
    (!cs_n_i) [*4] |-> serial_result_out_oe_o)
    else $error("serial out not driven while selected");
  a_sleep_entry: assert property (
    conv_done_i && cs_n_i |-> ##[1:3] sleep_o)
    else $error("no sleep after conversion");
  a_sleep_holds: assert property (
    cs_n_i [*4] ##0 sleep_o |=> sleep_o)
    else $error("sleep left while deselected");
  a_temp_speed: assert property (
    temp_input_select_o |-> !double_rate_select_o)
    else $error("double rate with temperature input");
  a_reject_valid: assert property (
    !(reject_select_a_o && reject_select_b_o))
    else $error("reserved rejection setting applied");
  a_drive_pullup: assert property (
    sck_oe_o |-> sck_pullup_o && serial_result_out_oe_o)
    else $error("clock pin driven outside internal mode");
  a_mode_internal: assert property (
    $fell(cs_n_i) && sck_i ##1 sck_i [*3] |-> ##[1:4] sck_pullup_o)
    else $error("internal clock mode not taken");
  a_mode_external: assert property (
    $fell(cs_n_i) && !sck_i ##1 (!sck_i) [*3] |-> ##[1:4] !sck_pullup_o)
    else $error("external clock mode not taken");
  a_tick_gap: assert property (
    gap_q <= 16'(EXT_IDLE + OSC_DIV + 8))
    else $error("conversion tick missing");
  a_apb_answer: assert property (
    psel_i && penable_i && !pready_o |-> ##[1:2] pready_o)
    else $error("bus access not answered");
  c_int_drive: cover property ($rose(sck_oe_o));
  c_sleep: cover property ($rose(sleep_o));
  c_abort: cover property ($rose(cs_n_i) && !sleep_o);
endmodule
bind acc_ctrl acc_assertions #(.EXT_IDLE(EXT_IDLE)) u_chk (
  .ref_clk_i, .sys_rst_i, .psel_i, .penable_i, .pready_o, .cs_n_i,
  .sck_i, .serial_result_out_oe_o, .sck_oe_o, .sck_pullup_o,
  .conv_done_i, .conv_tick_o, .sleep_o, .temp_input_select_o,
  .reject_select_a_o, .reject_select_b_o, .double_rate_select_o
);

// *** tb/acc_host.sv ***
// Host side of the serial link: select, shift clock, config input.
// Assumes the reference clock paces every pin change.
`timescale 1ns/1ps
module acc_host (
  input wire logic clk_i,
  input wire logic sdo_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic sdi_o
);
  logic [31:0] rx;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Hold select and clock levels between frames, data in low
  task automatic pins(input logic cs, input logic ck);
    cs_n_o <= cs;
    sck_o <= ck;
    sdi_o <= 1'b0;
  endtask
  // Frame of n clocks at 160 ns, config msb first
  task automatic frame(input int n, input logic [7:0] cfg);
    rx = 32'h0;
    cs_n_o <= 1'b0;
    wt(8);
    for (int i = 0; i < n; i++) begin
      sdi_o <= (i < 8) ? cfg[7-i] : ~sdi_o;
      wt(8);
      rx = {rx[30:0], sdo_i};
      sck_o <= 1'b1;
      wt(8);
      sck_o <= 1'b0;
    end
    wt(8);
    cs_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    wt(8);
  endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the converter cycle controller.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
module testbench
  import acc_pkg::*;
;
  logic clk, rst, psel, pen, pwr, pready, perr, irq, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic done, over, under, fen, f0, serial_result_out, oe, sck_w, sck_d, sck_oe;
  logic pull, tmp, fa, fb, dr, hcs, hsck, hsdi, sleep;
  logic sdo_w, sck_p, cstart;
  logic [24:0] res;
  logic [4:0] fc = 5'h00;
  int n_fail, check_count;
  int n_rise, n_start;
  // Pin levels: device clock wins while driving
  assign sck_w = sck_oe ? sck_d : hsck;
  assign f0 = fen & fc[4];
  assign sdo_w = oe ? serial_result_out : ~serial_result_out;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) fc <= fc + 5'h01;
  // Count device clock rises and conversion starts
  always @(posedge clk) begin
    sck_p <= sck_d;
    if (sck_d && !sck_p) n_rise <= n_rise + 1;
    if (cstart) n_start <= n_start + 1;
  end
  acc_ctrl #(.EXT_IDLE(50)) dut (
    .ref_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .irq_o(irq), .cs_n_i(hcs), .serial_config_in_i(hsdi),
    .serial_result_out_o(serial_result_out), .serial_result_out_oe_o(oe),
    .sck_i(sck_w), .sck_o(sck_d), .sck_oe_o(sck_oe),
    .sck_pullup_o(pull), .conv_clock_control_i(f0),
    .conv_done_i(done), .conv_result_i(res), .conv_over_i(over),
    .conv_under_i(under), .conv_start_o(cstart), .conv_tick_o(),
    .sleep_o(sleep), .temp_input_select_o(tmp),
    .reject_select_a_o(fa), .reject_select_b_o(fb),
    .double_rate_select_o(dr));
  acc_host h (.clk_i(clk), .sdo_i(sdo_w), .cs_n_o(hcs), .sck_o(hsck),
    .sdi_o(hsdi));
  task automatic results();
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus access, held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = perr;
    chk(n < 20, 32'h1);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // Analog core finishing a conversion
  task automatic conv(input logic [24:0] r, input logic o, input logic u);
    repeat (20) @(posedge clk);
    res <= r;
    over <= o;
    under <= u;
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    results();
  end
  initial begin
    {rst, psel, pen, pwr, done, over, under, fen} = 8'h80;
    {paddr, pwdata, res} = '0;
    n_fail = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, OFS_CFG, 32'h0);
    chk(rd, {28'h0, MODE_RESET});
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, OFS_IRQ_EN, 32'hf);
    fen <= 1'b1;
    repeat (200) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h10, 32'h10);
    fen <= 1'b0;
    repeat (120) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h10, 32'h0);
    conv(25'h0abcdef, 1'b0, 1'b0);
    chk({31'h0, sleep}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, OFS_IRQ_CLR, 32'hf);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    h.pins(1'b0, 1'b0);
    repeat (8) @(posedge clk);
    chk({30'h0, oe, serial_result_out}, 32'h2);
    h.pins(1'b1, 1'b0);
    repeat (8) @(posedge clk);
    chk({31'h0, sleep}, 32'h1);
    h.frame(32, 8'h8b);
    chk(h.rx, {3'b001, 25'h0abcdef, 4'h0});
    chk({28'h0, tmp, fa, fb, dr}, 32'ha);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'ha);
    conv(25'h0, 1'b1, 1'b0);
    h.frame(10, 8'h81);
    chk(h.rx, 32'h0c0);
    chk({28'h0, tmp, fa, fb, dr}, 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h7, 32'h1);
    conv(25'h0, 1'b0, 1'b1);
    h.frame(32, 8'h00);
    chk(h.rx, 32'h0fffffff);
    chk({31'h0, dr}, 32'h1);
    conv(25'h1, 1'b0, 1'b0);
    h.pins(1'b1, 1'b1);
    repeat (4) @(posedge clk);
    h.pins(1'b0, 1'b1);
    repeat (10) @(posedge clk);
    chk({30'h0, pull, sck_oe}, 32'h3);
    h.pins(1'b1, 1'b0);
    repeat (8) @(posedge clk);
    chk({31'h0, sleep}, 32'h1);
    // Internal clock frame paced by the external conversion clock
    apb(1'b1, OFS_IRQ_CLR, 32'hf);
    fen <= 1'b1;
    h.pins(1'b1, 1'b1);
    repeat (64) @(posedge clk);
    h.pins(1'b0, 1'b1);
    repeat (8600) @(posedge clk);
    chk(n_rise, 32'h20);
    chk({30'h0, oe, serial_result_out}, 32'h3);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h2);
    chk(n_start, 32'h5);
    h.pins(1'b1, 1'b0);
    repeat (8) @(posedge clk);
    results();
  end
endmodule
